//--- rtl/timer16_pkg.sv
// Purpose: Shared constants for the 16-bit timer/counter block
// Assumes: Byte-wide register port, one clock
// Notes:   Register indices are the block's own byte locations
package timer16_pkg;
  // Register indices on the byte port
  localparam logic [3:0] IDX_CTRL_A = 4'h0;
  localparam logic [3:0] IDX_CTRL_B = 4'h1;
  localparam logic [3:0] IDX_CNT_L  = 4'h2;
  localparam logic [3:0] IDX_CNT_H  = 4'h3;
  localparam logic [3:0] IDX_CMPA_L = 4'h4;
  localparam logic [3:0] IDX_CMPA_H = 4'h5;
  localparam logic [3:0] IDX_CMPB_L = 4'h6;
  localparam logic [3:0] IDX_CMPB_H = 4'h7;
  localparam logic [3:0] IDX_CAP_L  = 4'h8;
  localparam logic [3:0] IDX_CAP_H  = 4'h9;
  // Control A fields
  localparam int CA_ACT_A_POS   = 6;
  localparam int CA_ACT_B_POS   = 4;
  localparam int CA_FORCE_A_POS = 3;
  localparam int CA_FORCE_B_POS = 2;
  localparam int CA_WAVE_LO_POS = 0;
  // Control B fields
  localparam int CB_FILT_POS    = 7;
  localparam int CB_EDGE_POS    = 6;
  localparam int CB_WAVE_HI_POS = 3;
  localparam int CB_CLK_POS     = 0;
  // Flag positions on the flag outputs and clear inputs
  localparam int FL_OVF_POS = 0;
  localparam int FL_CMPB_POS = 1;
  localparam int FL_CMPA_POS = 2;
  localparam int FL_CAP_POS = 3;
  // Reset values
  localparam logic [7:0]  CTRL_RESET  = 8'h00;
  localparam logic [15:0] VALUE_RESET = 16'h0000;
  // Count limits
  localparam logic [15:0] TOP_MAX  = 16'hFFFF;
  localparam logic [15:0] TOP_8BIT = 16'h00FF;
  localparam logic [15:0] TOP_9BIT = 16'h01FF;
  localparam logic [15:0] TOP_10BIT = 16'h03FF;
  localparam logic [15:0] BOTTOM   = 16'h0000;
  // Clock select codes and prescaler tap widths (divide by 2**n)
  localparam logic [2:0] CLK_STOP     = 3'h0;
  localparam logic [2:0] CLK_DIV1     = 3'h1;
  localparam logic [2:0] CLK_DIV8     = 3'h2;
  localparam logic [2:0] CLK_DIV64    = 3'h3;
  localparam logic [2:0] CLK_DIV256   = 3'h4;
  localparam logic [2:0] CLK_DIV1024  = 3'h5;
  localparam logic [2:0] CLK_EXT_FALL = 3'h6;
  localparam logic [2:0] CLK_EXT_RISE = 3'h7;
  localparam int DIV8_BITS    = 3;
  localparam int DIV64_BITS   = 6;
  localparam int DIV256_BITS  = 8;
  localparam int DIV1024_BITS = 10;
  // Capture filter depth
  localparam int FILTER_SAMPLES = 4;
  // Compare output actions
  localparam logic [1:0] ACT_OFF    = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR  = 2'h2;
  localparam logic [1:0] ACT_SET    = 2'h3;
  // Waveform mode classes
  typedef enum logic [3:0] {
    CLS_SINGLE = 4'b0001,
    CLS_FAST   = 4'b0010,
    CLS_PHASE  = 4'b0100,
    CLS_PFC    = 4'b1000
  } mode_cls_e;
endpackage

//--- rtl/timer16_clk_sel.sv
// Purpose: Timer tick from prescaler taps or external count pin
// Assumes: External pin synchronous to the system clock
// Notes:   Tick is a one-cycle enable, not a clock
`timescale 1ns/1ps
module timer16_clk_sel
  import timer16_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  input  wire logic [2:0] sel_i,
  input  wire logic       ext_pin_i,
  output logic            tick_o
);
  logic [DIV1024_BITS-1:0] pre;
  logic                    ext_q;
  wire ext_rise = ext_pin_i & ~ext_q;
  wire ext_fall = ~ext_pin_i & ext_q;

  // Free-running prescaler and pin history
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      pre   <= '0;
      ext_q <= 1'b0;
    end else begin
      pre   <= pre + 1'b1;
      ext_q <= ext_pin_i;
    end
  end

  // Pin edges count even when the pin is driven as an output
  assign tick_o = (sel_i == CLK_DIV1)     ? 1'b1 :
                  (sel_i == CLK_DIV8)     ? &pre[DIV8_BITS-1:0] :
                  (sel_i == CLK_DIV64)    ? &pre[DIV64_BITS-1:0] :
                  (sel_i == CLK_DIV256)   ? &pre[DIV256_BITS-1:0] :
                  (sel_i == CLK_DIV1024)  ? &pre[DIV1024_BITS-1:0] :
                  (sel_i == CLK_EXT_FALL) ? ext_fall :
                  (sel_i == CLK_EXT_RISE) ? ext_rise : 1'b0;
endmodule

//--- rtl/timer16_capture_in.sv
// Purpose: Capture source select, noise filter and edge detect
// Assumes: Inputs synchronous to the system clock
// Notes:   Filter adds five cycles of delay when on
`timescale 1ns/1ps
module timer16_capture_in
  import timer16_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  input  wire logic pin_i,
  input  wire logic comp_i,
  input  wire logic src_sel_i,
  input  wire logic filt_en_i,
  input  wire logic edge_sel_i,
  input  wire logic enable_i,
  output logic      event_o
);
  logic [FILTER_SAMPLES-1:0] hist;
  logic                      filt;
  logic                      level_q;
  wire raw   = src_sel_i ? comp_i : pin_i;
  wire same  = (&hist) | ~(|hist);
  wire level = filt_en_i ? filt : raw;

  // Output follows only after four equal samples
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      hist    <= '0;
      filt    <= 1'b0;
      level_q <= 1'b0;
    end else begin
      hist    <= {hist[FILTER_SAMPLES-2:0], raw};
      filt    <= same ? hist[0] : filt;
      level_q <= level;
    end
  end

  // Rising when select is one, falling when zero
  assign event_o = enable_i & (edge_sel_i ? (level & ~level_q)
                                          : (~level & level_q));
endmodule

//--- rtl/timer16_core.sv
// Purpose: 16-bit timer/counter with compare, capture and byte registers
// Assumes: Byte register port, inputs synchronous to SYS_CLK_I
// Notes:   Reads answer one cycle after the read strobe
`timescale 1ns/1ps
module timer16_core
  import timer16_pkg::*;
(
  input  wire logic       SYS_CLK_I,
  input  wire logic       RST_B_I,
  input  wire logic [3:0] REG_ADDR_I,
  input  wire logic       REG_WR_I,
  input  wire logic       REG_RD_I,
  input  wire logic [7:0] REG_WDATA_I,
  output logic      [7:0] REG_RDATA_O,
  input  wire logic       CAPTURE_PIN_I,
  input  wire logic       COMPARATOR_I,
  input  wire logic       CAPTURE_SRC_SEL_I,
  input  wire logic       EXT_COUNT_PIN_I,
  input  wire logic [3:0] FLAG_CLR_I,
  output logic      [3:0] FLAGS_O,
  output logic            WAVE_OUT_A_O,
  output logic            WAVE_OUT_B_O,
  output logic            WAVE_EN_A_O,
  output logic            WAVE_EN_B_O
);
  // Control state
  logic [1:0]  act [2];
  logic [1:0]  wave_low;
  logic [1:0]  wave_high;
  logic        filt_en;
  logic        edge_sel;
  logic [2:0]  clk_sel;

  // Counter and data registers
  logic [15:0] count;
  logic [15:0] cmp_live [2];
  logic [15:0] cmp_buf [2];
  logic [15:0] capture;
  logic [7:0]  temp;
  logic [7:0]  rdata;
  logic        dir_down;
  logic        block_match;
  logic        hit_down;
  logic [1:0]  hit_q;
  logic [1:0]  wave;
  logic [3:0]  flags;

  // Mode decode results
  logic [3:0]  mode;
  mode_cls_e   cls;
  logic [15:0] top;
  logic        top_is_cap;
  logic [15:0] next_count;
  logic        next_dir;

  // Shared signals
  logic        tick;
  logic        cap_event;
  logic [1:0]  hit_now;
  logic [1:0]  force_hit;
  logic [1:0]  tog_ok;
  logic [3:0]  flag_set;

  // Write and read decode
  wire wr_ctrl_a = REG_WR_I & (REG_ADDR_I == IDX_CTRL_A);
  wire wr_ctrl_b = REG_WR_I & (REG_ADDR_I == IDX_CTRL_B);
  wire wr_cnt_l  = REG_WR_I & (REG_ADDR_I == IDX_CNT_L);
  wire wr_cmpa_l = REG_WR_I & (REG_ADDR_I == IDX_CMPA_L);
  wire wr_cmpb_l = REG_WR_I & (REG_ADDR_I == IDX_CMPB_L);
  wire wr_cap_l  = REG_WR_I & (REG_ADDR_I == IDX_CAP_L);
  wire wr_high   = REG_WR_I & ((REG_ADDR_I == IDX_CNT_H) |
                               (REG_ADDR_I == IDX_CMPA_H) |
                               (REG_ADDR_I == IDX_CMPB_H) |
                               (REG_ADDR_I == IDX_CAP_H));
  wire rd_cnt_l  = REG_RD_I & (REG_ADDR_I == IDX_CNT_L);
  wire rd_cmpa_l = REG_RD_I & (REG_ADDR_I == IDX_CMPA_L);
  wire rd_cmpb_l = REG_RD_I & (REG_ADDR_I == IDX_CMPB_L);
  wire rd_cap_l  = REG_RD_I & (REG_ADDR_I == IDX_CAP_L);

  // Full 16-bit word formed from latch and low byte
  wire [15:0] wr_word = {temp, REG_WDATA_I};
  wire [1:0]  wr_cmp_l = {wr_cmpb_l, wr_cmpa_l};

  // Mode from two control fields
  assign mode = {wave_high, wave_low};

  // Per-mode class and top source
  always_comb begin
    cls        = CLS_SINGLE;
    top        = TOP_MAX;
    top_is_cap = 1'b0;
    case (mode)
      4'h0: top = TOP_MAX;
      4'h4: top = cmp_live[0];
      4'hc: begin
        top        = capture;
        top_is_cap = 1'b1;
      end
      4'h1: begin
        cls = CLS_PHASE;
        top = TOP_8BIT;
      end
      4'h2: begin
        cls = CLS_PHASE;
        top = TOP_9BIT;
      end
      4'h3: begin
        cls = CLS_PHASE;
        top = TOP_10BIT;
      end
      4'ha: begin
        cls        = CLS_PHASE;
        top        = capture;
        top_is_cap = 1'b1;
      end
      4'hb: begin
        cls = CLS_PHASE;
        top = cmp_live[0];
      end
      4'h5: begin
        cls = CLS_FAST;
        top = TOP_8BIT;
      end
      4'h6: begin
        cls = CLS_FAST;
        top = TOP_9BIT;
      end
      4'h7: begin
        cls = CLS_FAST;
        top = TOP_10BIT;
      end
      4'he: begin
        cls        = CLS_FAST;
        top        = capture;
        top_is_cap = 1'b1;
      end
      4'hf: begin
        cls = CLS_FAST;
        top = cmp_live[0];
      end
      4'h8: begin
        cls        = CLS_PFC;
        top        = capture;
        top_is_cap = 1'b1;
      end
      4'h9: begin
        cls = CLS_PFC;
        top = cmp_live[0];
      end
      // Reserved mode 13 runs as a plain free count
      default: begin
        cls = CLS_SINGLE;
        top = TOP_MAX;
      end
    endcase
  end

  // Count sequence and turn points
  wire at_top    = (count == top);
  wire at_bottom = (count == BOTTOM);
  wire dual      = (cls == CLS_PHASE) | (cls == CLS_PFC);
  wire top_evt   = tick & at_top;
  wire bot_evt   = tick & at_bottom & dir_down;

  always_comb begin
    next_count = count;
    next_dir   = dual & dir_down;
    if (tick) begin
      if (!dual) begin
        next_count = at_top ? BOTTOM : count + 16'h0001;
      end else if (dir_down) begin
        next_count = at_bottom ? count + 16'h0001 : count - 16'h0001;
        next_dir   = ~at_bottom;
      end else begin
        next_count = at_top ? count - 16'h0001 : count + 16'h0001;
        next_dir   = at_top;
      end
    end
  end

  // Buffer load points per class
  wire upd_evt = ((cls == CLS_FAST) | (cls == CLS_PHASE)) ? top_evt :
                 (cls == CLS_PFC) ? bot_evt : 1'b0;

  // Overflow flag point per class
  wire ovf_evt = (cls == CLS_SINGLE) ? (tick & (count == TOP_MAX)) :
                 (cls == CLS_FAST)   ? top_evt : bot_evt;

  // Forced match only in non-PWM classes; never counts as a real match
  assign force_hit = {REG_WDATA_I[CA_FORCE_B_POS], REG_WDATA_I[CA_FORCE_A_POS]}
                     & {2{wr_ctrl_a & (cls == CLS_SINGLE)}};

  // Toggle action in PWM classes only for channel A in A-top modes
  assign tog_ok = {1'b0, (mode == 4'hf) | (mode == 4'h9) | (mode == 4'hb)};

  // Flag sources
  assign flag_set[FL_OVF_POS]  = ovf_evt;
  assign flag_set[FL_CMPA_POS] = hit_q[0];
  assign flag_set[FL_CMPB_POS] = hit_q[1];
  assign flag_set[FL_CAP_POS]  = cap_event | (top_evt & top_is_cap);

  // Output action step for one channel
  function automatic logic wave_step(input logic       cur,
                                     input logic [1:0] a,
                                     input mode_cls_e  c,
                                     input logic       hit,
                                     input logic       frc,
                                     input logic       tp,
                                     input logic       down,
                                     input logic       tok);
    logic r;
    r = cur;
    case (c)
      CLS_SINGLE: begin
        if (hit | frc) begin
          case (a)
            ACT_TOGGLE: r = ~cur;
            ACT_CLEAR:  r = 1'b0;
            ACT_SET:    r = 1'b1;
            default:    r = cur;
          endcase
        end
      end
      CLS_FAST: begin
        if (hit) begin
          if (a == ACT_CLEAR) r = 1'b0;
          else if (a == ACT_SET) r = 1'b1;
          else if ((a == ACT_TOGGLE) & tok) r = ~cur;
        end else if (tp) begin
          if (a == ACT_CLEAR) r = 1'b1;
          else if (a == ACT_SET) r = 1'b0;
        end
      end
      default: begin
        if (hit) begin
          if (a == ACT_CLEAR) r = down;
          else if (a == ACT_SET) r = ~down;
          else if ((a == ACT_TOGGLE) & tok) r = ~cur;
        end
      end
    endcase
    return r;
  endfunction

  // Compare channels
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_chan
      // Continuous compare, masked after a counter write
      assign hit_now[ch] = tick & ~block_match & (count == cmp_live[ch]);

      // Buffer takes writes; live copy follows at the update point, or takes the write at once in the single class
      always_ff @(posedge SYS_CLK_I) begin
        if (!RST_B_I) begin
          cmp_buf[ch]  <= VALUE_RESET;
          cmp_live[ch] <= VALUE_RESET;
          hit_q[ch]    <= 1'b0;
          wave[ch]     <= 1'b0;
        end else begin
          if (wr_cmp_l[ch]) begin
            cmp_buf[ch] <= wr_word;
          end
          if (wr_cmp_l[ch] & (cls == CLS_SINGLE)) begin
            cmp_live[ch] <= wr_word;
          end else if ((cls != CLS_SINGLE) & upd_evt) begin
            cmp_live[ch] <= cmp_buf[ch];
          end
          hit_q[ch] <= hit_now[ch];
          wave[ch]  <= wave_step(wave[ch], act[ch], cls, hit_q[ch],
                                 force_hit[ch], top_evt, hit_down,
                                 tog_ok[ch]);
        end
      end
    end
  endgenerate

  // Control registers; force bits are not stored
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_B_I) begin
      act[0]    <= CTRL_RESET[1:0];
      act[1]    <= CTRL_RESET[1:0];
      wave_low  <= CTRL_RESET[1:0];
      wave_high <= CTRL_RESET[1:0];
      filt_en   <= CTRL_RESET[0];
      edge_sel  <= CTRL_RESET[0];
      clk_sel   <= CTRL_RESET[2:0];
    end else begin
      if (wr_ctrl_a) begin
        act[0]   <= REG_WDATA_I[CA_ACT_A_POS +: 2];
        act[1]   <= REG_WDATA_I[CA_ACT_B_POS +: 2];
        wave_low <= REG_WDATA_I[CA_WAVE_LO_POS +: 2];
      end
      if (wr_ctrl_b) begin
        filt_en   <= REG_WDATA_I[CB_FILT_POS];
        edge_sel  <= REG_WDATA_I[CB_EDGE_POS];
        wave_high <= REG_WDATA_I[CB_WAVE_HI_POS +: 2];
        clk_sel   <= REG_WDATA_I[CB_CLK_POS +: 3];
      end
    end
  end

  // Counter, direction and match blocking
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_B_I) begin
      count       <= VALUE_RESET;
      dir_down    <= 1'b0;
      block_match <= 1'b0;
      hit_down    <= 1'b0;
    end else begin
      count       <= wr_cnt_l ? wr_word : next_count;
      dir_down    <= next_dir;
      // Block holds until the next timer tick after a write
      block_match <= wr_cnt_l | (block_match & ~tick);
      hit_down    <= tick ? dir_down : hit_down;
    end
  end

  // Capture register; event and software write share it
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_B_I) begin
      capture <= VALUE_RESET;
    end else if (cap_event) begin
      capture <= count;
    end else if (wr_cap_l) begin
      capture <= wr_word;
    end
  end

  // Sticky flags; a set in the same cycle as a clear wins
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_B_I) begin
      flags <= '0;
    end else begin
      flags <= flag_set | (flags & ~FLAG_CLR_I);
    end
  end

  // Read mux; reserved and force bits read zero
  wire [7:0] ctrl_a_rd = {act[0], act[1], 2'b00, wave_low};
  wire [7:0] ctrl_b_rd = {filt_en, edge_sel, 1'b0, wave_high, clk_sel};
  wire [7:0] read_mux =
    (REG_ADDR_I == IDX_CTRL_A) ? ctrl_a_rd :
    (REG_ADDR_I == IDX_CTRL_B) ? ctrl_b_rd :
    (REG_ADDR_I == IDX_CNT_L)  ? count[7:0] :
    (REG_ADDR_I == IDX_CMPA_L) ? cmp_buf[0][7:0] :
    (REG_ADDR_I == IDX_CMPB_L) ? cmp_buf[1][7:0] :
    (REG_ADDR_I == IDX_CAP_L)  ? capture[7:0] :
    ((REG_ADDR_I == IDX_CNT_H) | (REG_ADDR_I == IDX_CMPA_H) |
     (REG_ADDR_I == IDX_CMPB_H) | (REG_ADDR_I == IDX_CAP_H)) ? temp : 8'h00;

  // Low-byte read snapshots its high byte into the shared latch
  wire [7:0] snap_high = rd_cnt_l  ? count[15:8] :
                         rd_cmpa_l ? cmp_buf[0][15:8] :
                         rd_cmpb_l ? cmp_buf[1][15:8] : capture[15:8];
  wire       snap      = rd_cnt_l | rd_cmpa_l | rd_cmpb_l | rd_cap_l;

  // Shared latch and read data
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_B_I) begin
      temp  <= CTRL_RESET;
      rdata <= CTRL_RESET;
    end else begin
      if (wr_high) begin
        temp <= REG_WDATA_I;
      end else if (snap) begin
        temp <= snap_high;
      end
      if (REG_RD_I) begin
        rdata <= read_mux;
      end
    end
  end

  // Clock source selection
  timer16_clk_sel u_clk_sel (
    .clk_i     (SYS_CLK_I),
    .rst_b_i   (RST_B_I),
    .sel_i     (clk_sel),
    .ext_pin_i (EXT_COUNT_PIN_I),
    .tick_o    (tick)
  );

  // Capture front end, off while capture is the top
  timer16_capture_in u_capture_in (
    .clk_i      (SYS_CLK_I),
    .rst_b_i    (RST_B_I),
    .pin_i      (CAPTURE_PIN_I),
    .comp_i     (COMPARATOR_I),
    .src_sel_i  (CAPTURE_SRC_SEL_I),
    .filt_en_i  (filt_en),
    .edge_sel_i (edge_sel),
    .enable_i   (~top_is_cap),
    .event_o    (cap_event)
  );

  // Outputs
  assign REG_RDATA_O  = rdata;
  assign FLAGS_O      = flags;
  assign WAVE_OUT_A_O = wave[0];
  assign WAVE_OUT_B_O = wave[1];
  // Pin override whenever an action is chosen
  assign WAVE_EN_A_O  = (act[0] != ACT_OFF);
  assign WAVE_EN_B_O  = (act[1] != ACT_OFF);
endmodule

//--- test/timer16_sva.sv
// Purpose: Port checker for the timer core
// Assumes: Control bytes change only through the byte port
// Notes:   Shadow copies of both control bytes follow the writes
`timescale 1ns/1ps
module timer16_sva
  import timer16_pkg::*;
(
  input wire logic       SYS_CLK_I,
  input wire logic       RST_B_I,
  input wire logic [3:0] REG_ADDR_I,
  input wire logic       REG_WR_I,
  input wire logic       REG_RD_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic [7:0] REG_RDATA_O,
  input wire logic       CAPTURE_PIN_I,
  input wire logic       CAPTURE_SRC_SEL_I,
  input wire logic [3:0] FLAGS_O,
  input wire logic       WAVE_OUT_A_O,
  input wire logic       WAVE_EN_A_O
);
  logic [7:0] sh_a;
  logic [7:0] sh_b;
  // Forced set on channel A while the timer stands still, so no real hit
  wire frc = REG_WR_I && REG_ADDR_I == IDX_CTRL_A && REG_WDATA_I[CA_FORCE_A_POS]
    && REG_WDATA_I[7:6] == ACT_SET && sh_a[7:6] == ACT_SET && sh_b[2:0] == CLK_STOP;
  // Pin capture live: capture register is not the top
  wire cap_on = !(sh_b[4] && !sh_a[0]) && !CAPTURE_SRC_SEL_I && sh_b[CB_EDGE_POS];
  // Shadows of the control bytes
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_B_I) begin
      sh_a <= CTRL_RESET;
      sh_b <= CTRL_RESET;
    end else if (REG_WR_I && REG_ADDR_I == IDX_CTRL_A) begin
      sh_a <= REG_WDATA_I;
    end else if (REG_WR_I && REG_ADDR_I == IDX_CTRL_B) begin
      sh_b <= REG_WDATA_I;
    end
  end
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_B_I);
  property p_rd0;
    REG_RD_I && REG_ADDR_I == IDX_CTRL_A |=> REG_RDATA_O[3:2] == 2'b00;
  endproperty
  a_rd0: assert property (p_rd0) else $error("force bits read high");
  property p_resv;
    REG_RD_I && REG_ADDR_I == IDX_CTRL_B |=> !REG_RDATA_O[5];
  endproperty
  a_resv: assert property (p_resv) else $error("reserved bit read high");
  property p_en;
    WAVE_EN_A_O == (sh_a[7:6] != ACT_OFF);
  endproperty
  a_en: assert property (p_en) else $error("channel enable wrong");
  property p_frc;
    frc && sh_a[1:0] == 2'b00 && sh_b[4:3] != 2'b10 |-> ##[1:2] WAVE_OUT_A_O;
  endproperty
  a_frc: assert property (p_frc) else $error("forced set missing");
  property p_pwm;
    frc && sh_a[1:0] == 2'b01 && sh_b[4:3] == 2'b01 && !WAVE_OUT_A_O
      |=> (!WAVE_OUT_A_O)[*2];
  endproperty
  a_pwm: assert property (p_pwm) else $error("force acted in pwm");
  property p_nofl;
    frc |=> (!$rose(FLAGS_O[FL_CMPA_POS]))[*2];
  endproperty
  a_nofl: assert property (p_nofl) else $error("force raised flag");
  property p_cap;
    cap_on && !sh_b[CB_FILT_POS] && $rose(CAPTURE_PIN_I) |-> ##[1:2] FLAGS_O[FL_CAP_POS];
  endproperty
  a_cap: assert property (p_cap) else $error("capture flag missing");
  property p_filt;
    cap_on && sh_b[CB_FILT_POS] && $rose(CAPTURE_PIN_I) && !FLAGS_O[FL_CAP_POS]
      |=> (!FLAGS_O[FL_CAP_POS])[*3] ##[1:5] FLAGS_O[FL_CAP_POS];
  endproperty
  a_filt: assert property (p_filt) else $error("filter delay wrong");
  cover property (frc);
  cover property (cap_on && $rose(CAPTURE_PIN_I));
  cover property (REG_RD_I && REG_ADDR_I == IDX_CAP_L);
endmodule

bind timer16_core timer16_sva timer16_sva_inst (.SYS_CLK_I, .RST_B_I, .REG_ADDR_I,
  .REG_WR_I, .REG_RD_I, .REG_WDATA_I, .REG_RDATA_O, .CAPTURE_PIN_I, .CAPTURE_SRC_SEL_I,
  .FLAGS_O, .WAVE_OUT_A_O, .WAVE_EN_A_O);

//--- test/tb.sv
// Purpose: Self-checking bench for the timer core
// Assumes: Inputs change on the falling clock edge
// Notes:   Prescaled counts are checked as a window, phase is free
`timescale 1ns/1ps
module tb
  import timer16_pkg::*;
;
  logic        clk = 0, rst_b = 0, wr_s = 0, rd_s = 0, cap = 0, cmp = 0, src = 0, ext = 0;
  logic        woa, wob, wea, web;
  logic [3:0]  addr = '0, clr = '0, flags;
  logic [7:0]  wd = '0, rdat, b;
  logic [15:0] v;
  logic [7:0]  fa [4] = '{8'hC0, 8'h50, 8'hE0, 8'h80};
  logic [3:0]  fe [4] = '{4'hA, 4'h7, 4'hB, 4'h2};
  int          miscompares = 0, checks = 0;
  // 25 MHz system clock
  always #20 clk = ~clk;
  timer16_core timer16_core_inst (.SYS_CLK_I(clk), .RST_B_I(rst_b), .REG_ADDR_I(addr),
    .REG_WR_I(wr_s), .REG_RD_I(rd_s), .REG_WDATA_I(wd), .REG_RDATA_O(rdat),
    .CAPTURE_PIN_I(cap), .COMPARATOR_I(cmp), .CAPTURE_SRC_SEL_I(src), .EXT_COUNT_PIN_I(ext),
    .FLAG_CLR_I(clr), .FLAGS_O(flags), .WAVE_OUT_A_O(woa), .WAVE_OUT_B_O(wob),
    .WAVE_EN_A_O(wea), .WAVE_EN_B_O(web));
  // Closing report, also reached by the watchdog
  task automatic wrap_up;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Idle cycle between accesses keeps each strobe a single pulse
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wd = d;
    wr_s = 1;
    @(negedge clk);
    wr_s = 0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(negedge clk);
    addr = a;
    rd_s = 1;
    @(negedge clk);
    rd_s = 0;
    b = rdat;
  endtask
  // High byte first on writes, low byte first on reads
  task automatic wr16(input logic [3:0] a, input logic [15:0] d);
    wr(a + 4'h1, d[15:8]);
    wr(a, d[7:0]);
  endtask
  task automatic rd16(input logic [3:0] a, input logic [15:0] e);
    rd(a);
    v[7:0] = b;
    rd(a + 4'h1);
    v[15:8] = b;
    chk(v, e);
  endtask
  task automatic clrf;
    @(negedge clk);
    clr = 4'hF;
    @(negedge clk);
    clr = 4'h0;
  endtask
  // One capture source change, then the capture flag after three cycles
  task automatic ev(input logic [7:0] c, input logic s, input logic p, input logic e);
    wr(IDX_CTRL_B, c);
    src = s;
    clrf();
    if (s)
      cmp = p;
    else
      cap = p;
    repeat (3) @(negedge clk);
    chk({15'h0, flags[FL_CAP_POS]}, {15'h0, e});
  endtask
  initial begin
    #2000000;
    miscompares++;
    wrap_up();
  end
  initial begin
    repeat (6) @(negedge clk);
    rst_b = 1;
    for (int i = 0; i < 16; i += 5) begin
      rd(i[3:0]);
      chk({8'h0, b}, 16'h0000);
    end
    for (int i = 0; i < 4; i++) begin
      wr(IDX_CTRL_A, fa[i]);
      wr(IDX_CTRL_A, fa[i] | 8'h0C);
      @(negedge clk);
      chk({12'h0, woa, wob, wea, web}, {12'h0, fe[i]});
    end
    rd(IDX_CTRL_A);
    chk({4'h0, flags, b}, 16'h0080);
    wr(IDX_CTRL_B, 8'h08);
    rd(IDX_CTRL_B);
    chk({8'h0, b}, 16'h0008);
    wr(IDX_CTRL_A, 8'hC1);
    wr(IDX_CTRL_A, 8'hC9);
    rd(IDX_CTRL_A);
    chk({7'h0, woa, b}, 16'h00C1);
    wr(IDX_CTRL_B, 8'h00);
    wr(IDX_CTRL_A, 8'h00);
    $display("test control done");
    wr16(IDX_CNT_L, 16'h1234);
    rd16(IDX_CNT_L, 16'h1234);
    wr(IDX_CAP_H, 8'h56);
    wr(IDX_CNT_L, 8'h78);
    rd16(IDX_CNT_L, 16'h5678);
    wr16(IDX_CMPA_L, 16'h0010);
    rd16(IDX_CMPA_L, 16'h0010);
    wr16(IDX_CMPB_L, 16'h0040);
    wr16(IDX_CNT_L, 16'h0000);
    $display("test latch done");
    wr(IDX_CTRL_B, 8'h01);
    repeat (8) @(negedge clk);
    chk({15'h0, flags[FL_CMPA_POS]}, 16'h0000);
    repeat (20) @(negedge clk);
    chk({15'h0, flags[FL_CMPA_POS]}, 16'h0001);
    wr(IDX_CTRL_B, 8'h00);
    wr16(IDX_CNT_L, 16'h0040);
    clrf();
    wr(IDX_CTRL_B, 8'h01);
    repeat (4) @(negedge clk);
    chk({14'h0, flags[2:1]}, 16'h0000);
    wr16(IDX_CNT_L, 16'hFFF0);
    repeat (20) @(negedge clk);
    chk({15'h0, flags[FL_OVF_POS]}, 16'h0001);
    wr(IDX_CTRL_B, 8'h00);
    $display("test compare done");
    wr16(IDX_CNT_L, 16'h0000);
    wr(IDX_CTRL_B, {5'h00, CLK_DIV8});
    repeat (80) @(negedge clk);
    wr(IDX_CTRL_B, 8'h00);
    rd(IDX_CNT_L);
    chk({15'h0, b inside {[8'h0A:8'h0B]}}, 16'h0001);
    for (int i = 6; i < 8; i++) begin
      wr16(IDX_CNT_L, 16'h0000);
      wr(IDX_CTRL_B, i[7:0]);
      repeat (5) begin
        @(negedge clk);
        ext = 1;
        @(negedge clk);
        ext = 0;
      end
      wr(IDX_CTRL_B, 8'h00);
      rd16(IDX_CNT_L, 16'h0005);
    end
    // Ten ticks from FC: phase correct turns at FF, fast 8-bit wraps to zero
    wr(IDX_CTRL_A, 8'h01);
    for (int i = 0; i < 2; i++) begin
      wr16(IDX_CNT_L, 16'h00FC);
      clrf();
      wr(IDX_CTRL_B, {4'h0, i[0], 3'h1});
      repeat (8) @(negedge clk);
      wr(IDX_CTRL_B, {4'h0, i[0], 3'h0});
      rd16(IDX_CNT_L, (i == 1) ? 16'h0006 : 16'h00F8);
      chk({15'h0, flags[FL_OVF_POS]}, {15'h0, i[0]});
    end
    wr(IDX_CTRL_A, 8'h00);
    $display("test clock done");
    wr16(IDX_CNT_L, 16'h1234);
    ev(8'h40, 1'b0, 1'b1, 1'b1);
    rd16(IDX_CAP_L, 16'h1234);
    ev(8'h00, 1'b0, 1'b0, 1'b1);
    ev(8'hC0, 1'b0, 1'b1, 1'b0);
    repeat (6) @(negedge clk);
    chk({15'h0, flags[FL_CAP_POS]}, 16'h0001);
    ev(8'h40, 1'b1, 1'b1, 1'b1);
    ev(8'h58, 1'b0, 1'b0, 1'b0);
    ev(8'h58, 1'b0, 1'b1, 1'b0);
    $display("test capture done");
    wrap_up();
  end
endmodule
